/* File: testbench/pmt_timer_sva.sv */
`timescale 1ns/1ps
module pmt_timer_sva
    import pmt_pkg::*;
(
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0] pstrb,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic irq,
    input logic serial_shift_clk,
    input logic pwm_time_base_match,
    input logic [7:0] pwm_time_base_count
);
    // ==========================================
    // Decode helpers
    logic mapped;
    logic acc;
    logic rdacc;
    assign mapped = paddr inside {PMT_CTRL_OFS, PMT_COUNT_OFS, PMT_LIMIT_OFS,
        PMT_FLAGS_OFS, PMT_CLEAR_OFS, PMT_ENABLE_OFS};
    assign acc = psel && penable;
    assign rdacc = acc && !pwrite;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Instruction clock forbids ticks closer than four cycles
    sequence quiet3;
        !pwm_time_base_match [*3];
    endsequence

    // ==========================================
    // Properties
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_slverr_map: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr decode wrong");
    a_unmapped_zero: assert property (rdacc && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (rdacc && mapped |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_ctrl_bit7: assert property (rdacc && paddr == PMT_CTRL_OFS |-> !prdata[7])
        else $error("control bit 7 set");
    a_match_pair: assert property (serial_shift_clk == pwm_time_base_match)
        else $error("match outputs differ");
    a_match_space: assert property (pwm_time_base_match |=> quiet3)
        else $error("match pulses too close");
    a_count_step: assert property ($changed(pwm_time_base_count) |->
        pwm_time_base_count == $past(pwm_time_base_count) + 8'h01
        || pwm_time_base_count == 8'h00 || $past(acc && pwrite) || $past(acc && pwrite, 2))
        else $error("count jumped");
    a_irq_clear: assert property ($fell(irq) |-> $past(acc && pwrite))
        else $error("irq fell without write");
endmodule

bind pmt_timer pmt_timer_sva i_pmt_timer_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .serial_shift_clk(serial_shift_clk), .pwm_time_base_match(pwm_time_base_match),
    .pwm_time_base_count(pwm_time_base_count));

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb
    import pmt_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, err, irq, ssc, mt, rdy, se;
    logic [3:0] strb;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, n, m;
    logic [7:0] cnt;
    logic [31:0] pre [4] = '{32'h1, 32'h4, 32'h10, 32'h10};
    logic [3:0] fs [3] = '{4'h0, 4'h3, 4'hf};
    int fails = 0;
    int checked = 0;

    pmt_timer i_pmt_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(strb), .prdata(prdata), .pready(rdy), .pslverr(err), .irq(irq),
        .serial_shift_clk(ssc), .pwm_time_base_match(mt), .pwm_time_base_count(cnt));

    // ==========================================
    // Clock and watchdog
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        finish_test();
    end

    // ==========================================
    // Bus and compare tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            fails++;
            $display("mismatch t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    // One idle cycle before setup keeps every release in its own step
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (rdy !== 1'b1);
        rd = prdata;
        se = err;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // Cycles up to the next match pulse
    task automatic gap();
        n = 0;
        do begin @(posedge pclk); n++; end while (mt !== 1'b1 && n < 3000);
    endtask
    task automatic finish_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================
    // Test sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        strb = 4'hf;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(PMT_CTRL_OFS, 32'h0);
        rdchk(PMT_COUNT_OFS, 32'h0);
        rdchk(PMT_LIMIT_OFS, 32'hff);
        rdchk(PMT_FLAGS_OFS, 32'h0);
        rdchk(12'h018, 32'h0);
        chk({31'h0, se}, 32'h1);
        xfer(1'b1, PMT_CTRL_OFS, 32'hff);
        rdchk(PMT_CTRL_OFS, 32'h7f);
        xfer(1'b1, PMT_CTRL_OFS, 32'h0);
        xfer(1'b1, PMT_LIMIT_OFS, 32'h5a);
        xfer(1'b1, PMT_COUNT_OFS, 32'h05);
        xfer(1'b1, PMT_CTRL_OFS, 32'h78);
        repeat (40) @(posedge pclk);
        // Write without byte lane 0 must leave the limit alone
        strb <= 4'h0;
        xfer(1'b1, PMT_LIMIT_OFS, 32'h33);
        strb <= 4'hf;
        rdchk(PMT_LIMIT_OFS, 32'h5a);
        rdchk(PMT_COUNT_OFS, 32'h05);
        chk({24'h0, cnt}, 32'h05);
        $display("register test done");
        // Match period for every prescale code, limit of one
        for (int c = 0; c < 4; c++)
        begin
            xfer(1'b1, PMT_CTRL_OFS, 32'h0);
            xfer(1'b1, PMT_COUNT_OFS, 32'h0);
            xfer(1'b1, PMT_LIMIT_OFS, 32'h1);
            xfer(1'b1, PMT_CTRL_OFS, 32'h4 | c);
            gap();
            gap();
            chk({31'h0, ssc}, 32'h1);
            chk(n, 32'h8 * pre[c]);
        end
        $display("prescale test done");
        // Matches needed before the interrupt, per postscale field
        xfer(1'b1, PMT_LIMIT_OFS, 32'h0);
        xfer(1'b1, PMT_ENABLE_OFS, 32'h2);
        for (int i = 0; i < 3; i++)
        begin
            xfer(1'b1, PMT_CTRL_OFS, 32'h0);
            xfer(1'b1, PMT_CLEAR_OFS, 32'h2);
            xfer(1'b1, PMT_CTRL_OFS, 32'h4 | (fs[i] << 3));
            m = 0;
            n = 0;
            while (irq !== 1'b1 && n < 300)
            begin
                @(posedge pclk);
                if (mt === 1'b1)
                    m++;
                n++;
            end
            chk(m, fs[i] + 32'h1);
        end
        xfer(1'b1, PMT_CTRL_OFS, 32'h0);
        xfer(1'b1, PMT_ENABLE_OFS, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rdchk(PMT_FLAGS_OFS, 32'h2);
        xfer(1'b1, PMT_CLEAR_OFS, 32'h2);
        rdchk(PMT_FLAGS_OFS, 32'h0);
        $display("interrupt test done");
        // Reset in mid-run
        xfer(1'b1, PMT_LIMIT_OFS, 32'hc8);
        xfer(1'b1, PMT_CTRL_OFS, 32'h4);
        repeat (30) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(PMT_COUNT_OFS, 32'h0);
        rdchk(PMT_CTRL_OFS, 32'h0);
        $display("reset test done");
        finish_test();
    end
endmodule

/* File: verilog/pmt_pkg.sv */
package pmt_pkg;

    // ==========================================
    // Register map (byte addresses)
    localparam logic [11:0] PMT_CTRL_OFS = 12'h000;
    localparam logic [11:0] PMT_COUNT_OFS = 12'h004;
    localparam logic [11:0] PMT_LIMIT_OFS = 12'h008;
    localparam logic [11:0] PMT_FLAGS_OFS = 12'h00c;
    localparam logic [11:0] PMT_CLEAR_OFS = 12'h010;
    localparam logic [11:0] PMT_ENABLE_OFS = 12'h014;

    // ==========================================
    // Control and flag field layout
    localparam int PMT_PRE_LSB = 0;
    localparam int PMT_PRE_MSB = 1;
    localparam int PMT_RUN_BIT = 2;
    localparam int PMT_POST_LSB = 3;
    localparam int PMT_POST_MSB = 6;
    localparam int PMT_MATCH_FLAG_BIT = 1;

    // ==========================================
    // Reset values
    localparam logic [6:0] PMT_CTRL_RST = 7'h00;
    localparam logic [7:0] PMT_COUNT_RST = 8'h00;
    localparam logic [7:0] PMT_LIMIT_RST = 8'hff;
    localparam logic [7:0] PMT_FLAGS_RST = 8'h00;

    // ==========================================
    // Timing: instruction clock is the bus clock divided by four
    localparam logic [1:0] PMT_ICLK_DIV_LAST = 2'h3;
    localparam logic [3:0] PMT_PRE_LAST_4 = 4'h3;
    localparam logic [3:0] PMT_PRE_LAST_16 = 4'hf;

    // Prescale select codes
    typedef enum logic [1:0]
    {
        PMT_PRE_DIV1 = 2'b00,
        PMT_PRE_DIV4 = 2'b01
    } pmt_pre_e;

endpackage

/* File: verilog/pmt_postscaler.sv */
`timescale 1ns/1ps
module pmt_postscaler
    import pmt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic match,
    input wire logic [3:0] ratio,
    output logic event_out
);

    logic [3:0] post_r;
    logic [3:0] post_nxt;
    logic ev_nxt;

    // ==========================================
    // Match divider, ratio is field plus one
    always_comb
    begin
        post_nxt = post_r;
        ev_nxt = 1'b0;
        if (clear)
        begin
            post_nxt = 4'h0;
        end
        else if (match)
        begin
            if (post_r >= ratio)
            begin
                post_nxt = 4'h0;
                ev_nxt = 1'b1;
            end
            else
            begin
                post_nxt = post_r + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            post_r <= 4'h0;
            event_out <= 1'b0;
        end
        else
        begin
            post_r <= post_nxt;
            event_out <= ev_nxt;
        end
    end

endmodule

/* File: verilog/pmt_prescaler.sv */
`timescale 1ns/1ps
module pmt_prescaler
    import pmt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [1:0] sel,
    pmt_tick_if.scaler lnk
);

    logic [1:0] phase_r;
    logic [1:0] phase_nxt;
    logic [3:0] pre_r;
    logic [3:0] pre_nxt;
    logic tick_nxt;
    logic [3:0] last;

    // ==========================================
    // Instruction clock and prescaler
    always_comb
    begin
        phase_nxt = phase_r;
        pre_nxt = pre_r;
        tick_nxt = 1'b0;
        // Divide by 1, 4 or 16
        case (sel)
            PMT_PRE_DIV1: last = 4'h0;
            PMT_PRE_DIV4: last = PMT_PRE_LAST_4;
            default: last = PMT_PRE_LAST_16;
        endcase
        if (lnk.clear)
        begin
            phase_nxt = 2'h0;
            pre_nxt = 4'h0;
        end
        else if (run)
        begin
            phase_nxt = phase_r + 2'h1;
            if (phase_r == PMT_ICLK_DIV_LAST)
            begin
                if (pre_r >= last)
                begin
                    pre_nxt = 4'h0;
                    tick_nxt = 1'b1;
                end
                else
                begin
                    pre_nxt = pre_r + 4'h1;
                end
            end
        end
    end

    // Registers only; stopped timer holds its phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_r <= 2'h0;
            pre_r <= 4'h0;
            lnk.tick <= 1'b0;
        end
        else
        begin
            phase_r <= phase_nxt;
            pre_r <= pre_nxt;
            lnk.tick <= tick_nxt;
        end
    end

endmodule

/* File: verilog/pmt_tick_if.sv */
`timescale 1ns/1ps
// Scaler-to-core link: clear request and prescaled tick
interface pmt_tick_if;
    logic clear;
    logic tick;
    modport core (output clear, input tick);
    modport scaler (input clear, output tick);
endinterface

/* File: verilog/pmt_timer.sv */
`timescale 1ns/1ps
module pmt_timer
    import pmt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic serial_shift_clk,
    output logic pwm_time_base_match,
    output logic [7:0] pwm_time_base_count
);

    logic [6:0] ctrl_r;
    logic [6:0] ctrl_nxt;
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic [7:0] limit_r;
    logic [7:0] limit_nxt;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] enable_r;
    logic [7:0] enable_nxt;
    logic match_r;
    logic match_nxt;
    logic [31:0] rdata_nxt;
    logic [31:0] rdata_r;
    logic wr;
    logic rd;
    logic lane0;
    logic hit;
    logic post_event;

    pmt_tick_if tlnk();

    // ==========================================
    // APB decode; zero wait states
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    assign lane0 = pstrb[0];
    assign pready = 1'b1;
    always_comb
    begin
        case (paddr)
            PMT_CTRL_OFS, PMT_COUNT_OFS, PMT_LIMIT_OFS,
            PMT_FLAGS_OFS, PMT_CLEAR_OFS, PMT_ENABLE_OFS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    // Unmapped addresses answer with an error
    assign pslverr = psel & penable & ~hit;

    // clear on counter or control write
    assign tlnk.clear = wr & lane0 & ((paddr == PMT_COUNT_OFS) | (paddr == PMT_CTRL_OFS));

    // ==========================================
    // Prescaler and postscaler
    pmt_prescaler u_pre
    (
        .pclk(pclk),
        .presetn(presetn),
        .run(ctrl_r[PMT_RUN_BIT]),
        .sel(ctrl_r[PMT_PRE_MSB:PMT_PRE_LSB]),
        .lnk(tlnk.scaler)
    );

    pmt_postscaler u_post
    (
        .pclk(pclk),
        .presetn(presetn),
        .clear(tlnk.clear),
        .match(match_r),
        .ratio(ctrl_r[PMT_POST_MSB:PMT_POST_LSB]),
        .event_out(post_event)
    );

    // ==========================================
    // Counter and register writes
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        count_nxt = count_r;
        limit_nxt = limit_r;
        enable_nxt = enable_r;
        match_nxt = 1'b0;
        if (tlnk.tick)
        begin
            if (count_r == limit_r)
            begin
                count_nxt = 8'h00;
                match_nxt = 1'b1;
            end
            else
            begin
                count_nxt = count_r + 8'h01;
            end
        end
        if (wr & lane0)
        begin
            case (paddr)
                PMT_CTRL_OFS: ctrl_nxt = pwdata[6:0];
                // software writes counter, wins over tick
                PMT_COUNT_OFS: count_nxt = pwdata[7:0];
                PMT_LIMIT_OFS: limit_nxt = pwdata[7:0];
                PMT_ENABLE_OFS: enable_nxt = pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // Sticky flags; set beats clear
    always_comb
    begin
        flags_nxt = flags_r;
        if (wr & lane0 & (paddr == PMT_CLEAR_OFS))
        begin
            flags_nxt = flags_r & ~pwdata[7:0];
        end
        if (post_event)
        begin
            flags_nxt[PMT_MATCH_FLAG_BIT] = 1'b1;
        end
    end

    // ==========================================
    // Read mux; registered on setup so data is stable in access
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (rd)
        begin
            case (paddr)
                PMT_CTRL_OFS: rdata_nxt = {25'h0, ctrl_r};
                PMT_COUNT_OFS: rdata_nxt = {24'h0, count_r};
                PMT_LIMIT_OFS: rdata_nxt = {24'h0, limit_r};
                PMT_FLAGS_OFS: rdata_nxt = {24'h0, flags_r};
                PMT_ENABLE_OFS: rdata_nxt = {24'h0, enable_r};
                default: rdata_nxt = 32'h0;
            endcase
        end
    end
    assign prdata = rdata_r;

    // ==========================================
    // State registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= PMT_CTRL_RST;
            count_r <= PMT_COUNT_RST;
            limit_r <= PMT_LIMIT_RST;
            flags_r <= PMT_FLAGS_RST;
            enable_r <= PMT_FLAGS_RST;
            match_r <= 1'b0;
            rdata_r <= 32'h0;
            irq <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            count_r <= count_nxt;
            limit_r <= limit_nxt;
            flags_r <= flags_nxt;
            enable_r <= enable_nxt;
            match_r <= match_nxt;
            rdata_r <= rdata_nxt;
            irq <= |(flags_nxt & enable_nxt);
        end
    end

    // ==========================================
    // Outputs to neighbouring units
    // match pulse as shift clock source
    assign serial_shift_clk = match_r;
    assign pwm_time_base_match = match_r;
    assign pwm_time_base_count = count_r;

endmodule
